// file: bil_pkg.sv
// package for the boot image loader and security configuration block
// assumes a single 10 MHz clock domain and one design module
package bil_pkg;
  localparam logic [31:0] BIL_BYPASS_WORD  = 32'h0D15AB1E;
  localparam logic [31:0] BIL_CRC_POLY     = 32'hEDB88320;
  localparam logic [31:0] BIL_CRC_PRESET   = 32'hFFFFFFFF;
  localparam logic [31:0] BIL_SEC_RESET    = 32'h00000000;
  localparam int          BIL_RAM_AW       = 15;
  localparam logic [14:0] BIL_RAM_BASE     = 15'h0000;
  localparam int          BIL_OTP_AW       = 11;
  localparam int          BIL_OTP_ROWS     = 512;
  localparam int          BIL_OTP_SECTORS  = 4;
  localparam logic [10:0] BIL_OTP_SEC_ADDR = 11'h7FF;
  localparam logic [10:0] BIL_OTP_BOOT     = 11'h000;
  localparam logic [23:0] BIL_RES_OTP_ADDR = 24'h100200;
  localparam logic [23:0] BIL_RES_OTP_DATA = 24'h200100;
  localparam logic [23:0] BIL_RES_OTP_CTRL = 24'h100300;
  // security field positions
  localparam int BIL_SB_NO_JTAG   = 0;
  localparam int BIL_SB_NO_LINK   = 1;
  localparam int BIL_SB_SEC_BOOT  = 5;
  localparam int BIL_SB_REDUNDANT = 7;
  localparam int BIL_SB_LOCK0     = 8;
  localparam int BIL_SB_MASTER    = 12;
  localparam int BIL_SB_NO_JOTP   = 13;
  localparam int BIL_SB_NO_DEBUG  = 14;
  localparam int BIL_SB_USER_LO   = 15;
  localparam int BIL_SB_USER_HI   = 21;
  localparam int BIL_SB_ID_LO     = 22;
  localparam int BIL_SB_ID_HI     = 31;
  // register port map
  localparam logic [3:0] BIL_REG_SEC    = 4'h0;
  localparam logic [3:0] BIL_REG_STATUS = 4'h1;
  localparam logic [3:0] BIL_REG_CRC    = 4'h2;
  localparam logic [3:0] BIL_REG_LEN    = 4'h3;
  localparam logic [3:0] BIL_REG_OTPA   = 4'h4;
  localparam logic [3:0] BIL_REG_OTPD   = 4'h5;
  localparam logic [3:0] BIL_REG_OTPC   = 4'h6;
  localparam logic [3:0] BIL_REG_USER   = 4'h7;
  localparam logic [15:0] BIL_OTPC_PROG = 16'h0001;

  typedef enum logic [1:0] {
    BIL_PRIV_OK, BIL_PRIV_REFUSED
  } bil_priv_e;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } bil_byte_s;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } bil_reg_req_s;

  typedef struct packed {
    logic        jtag_block;
    logic        link_block;
    logic        secure_boot;
    logic        redundant_rows;
    logic        jtag_otp_block;
    logic        debug_ignore;
    logic [9:0]  usercode_ext;
  } bil_sec_s;
endpackage : bil_pkg

// file: bil_loader.sv
// boot image loader: crc check, ram placement, otp security register
// assumes byte stream from an outside source; the debug request pin is
// synchronised inside by two flops; single clock domain
//////////////////////////////////////////////////////////////////////////
module bil_loader
  import bil_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire bil_pkg::bil_byte_s        img_byte,
  output logic                           img_ready,
  input  wire logic [31:0]               otp_rdata,
  output logic [bil_pkg::BIL_OTP_AW-1:0] otp_raddr,
  output logic                           otp_prog,
  output logic [bil_pkg::BIL_OTP_AW-1:0] otp_paddr,
  output logic [31:0]                    otp_pdata,
  output logic                           otp_redundant,
  output logic                           ram_we,
  output logic [bil_pkg::BIL_RAM_AW-1:0] ram_addr,
  output logic [31:0]                    ram_wdata,
  output logic                           cpu_start,
  output logic [bil_pkg::BIL_RAM_AW-1:0] cpu_start_addr,
  output logic                           boot_fail,
  output logic                           sec_valid,
  input  wire logic                      jtag_req,
  output logic                           jtag_grant,
  input  wire logic                      jtag_otp_req,
  output logic                           jtag_otp_grant,
  input  wire logic                      link_req,
  output logic                           link_grant,
  input  wire logic                      debug_n_pin,
  output logic                           debug_req,
  output logic [9:0]                     usercode_ext,
  input  wire bil_pkg::bil_reg_req_s     reg_req,
  output logic [31:0]                    reg_rdata
);
  import bil_pkg::*;

  typedef enum logic [3:0] {
    ST_SEC_ADDR, ST_SEC_READ, ST_OTP_ADDR, ST_OTP_READ, ST_LEN, ST_PROG,
    ST_CRC, ST_CHECK, ST_RUN, ST_FAIL
  } bil_state_e;

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ BIL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  function automatic logic sector_locked(input logic [31:0] s,
                                         input logic [10:0] a);
    return s[BIL_SB_MASTER] | s[BIL_SB_LOCK0 + int'(a[10:9])];
  endfunction : sector_locked

  bil_state_e  state;
  logic [31:0] sec;
  logic [31:0] shreg;
  logic [1:0]  bcnt;
  logic [31:0] words_left;
  logic [31:0] len_word;
  logic [31:0] crc;
  logic [31:0] crc_rx;
  logic        dbg_s1;
  logic        dbg_s2;
  logic [15:0] otpa;
  logic [31:0] otpd;
  logic [6:0]  user_field;
  logic        prog_refused;
  logic        take;
  logic [31:0] next_shreg;

  assign take       = img_byte.valid & img_ready;
  assign next_shreg = {img_byte.data, shreg[31:8]};

  //////////////////////////////////////////////////////////////////////////
  // boot sequence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= ST_SEC_ADDR;
      otp_raddr  <= BIL_OTP_SEC_ADDR;
      sec        <= BIL_SEC_RESET;
      sec_valid  <= 1'b0;
      img_ready  <= 1'b0;
      bcnt       <= 2'd0;
      shreg      <= 32'h00000000;
      words_left <= 32'h00000000;
      len_word   <= 32'h00000000;
      crc        <= BIL_CRC_PRESET;
      crc_rx     <= 32'h00000000;
      ram_we     <= 1'b0;
      ram_addr   <= BIL_RAM_BASE;
      ram_wdata  <= 32'h00000000;
      cpu_start  <= 1'b0;
      cpu_start_addr <= BIL_RAM_BASE;
      boot_fail  <= 1'b0;
    end else begin
      ram_we <= 1'b0;
      unique case (state)
        ST_SEC_ADDR: state <= ST_SEC_READ;
        ST_SEC_READ: begin
          sec       <= otp_rdata;
          sec_valid <= 1'b1;
          otp_raddr <= BIL_OTP_BOOT;
          ram_addr  <= BIL_RAM_BASE;
          state     <= otp_rdata[BIL_SB_SEC_BOOT] ? ST_OTP_ADDR : ST_LEN;
          img_ready <= ~otp_rdata[BIL_SB_SEC_BOOT];
        end
        ST_OTP_ADDR: state <= ST_OTP_READ;
        ST_OTP_READ: begin
          // copy otp rows below the security word into sram
          ram_we    <= 1'b1;
          ram_wdata <= otp_rdata;
          ram_addr  <= BIL_RAM_AW'(otp_raddr);
          if (otp_raddr == BIL_OTP_SEC_ADDR - 11'd1) begin
            cpu_start      <= 1'b1;
            cpu_start_addr <= BIL_RAM_BASE;
            state          <= ST_RUN;
          end else begin
            otp_raddr <= otp_raddr + 11'd1;
            state     <= ST_OTP_ADDR;
          end
        end
        ST_LEN: if (take) begin
          shreg <= next_shreg;
          bcnt  <= bcnt + 2'd1;
          crc   <= crc_byte(crc, img_byte.data);
          if (bcnt == 2'd3) begin
            len_word   <= next_shreg;
            words_left <= next_shreg;
            state      <= (next_shreg == 32'h0) ? ST_CRC : ST_PROG;
          end
        end
        ST_PROG: if (take) begin
          shreg <= next_shreg;
          bcnt  <= bcnt + 2'd1;
          crc   <= crc_byte(crc, img_byte.data);
          if (bcnt == 2'd3) begin
            ram_we     <= 1'b1;
            ram_wdata  <= next_shreg;
            ram_addr   <= BIL_RAM_AW'(len_word - words_left);
            words_left <= words_left - 32'd1;
            if (words_left == 32'd1) begin
              state <= ST_CRC;
            end
          end
        end
        ST_CRC: if (take) begin
          shreg <= next_shreg;  // crc word not hashed
          bcnt  <= bcnt + 2'd1;
          if (bcnt == 2'd3) begin
            crc_rx    <= next_shreg;
            img_ready <= 1'b0;
            state     <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (crc_rx == BIL_BYPASS_WORD || crc_rx == ~crc) begin
            cpu_start      <= 1'b1;
            cpu_start_addr <= BIL_RAM_BASE;
            state          <= ST_RUN;
          end else begin
            boot_fail <= 1'b1;
            state     <= ST_FAIL;
          end
        end
        ST_RUN:  cpu_start <= 1'b0;
        ST_FAIL: boot_fail <= 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // security gating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dbg_s1 <= 1'b1;
      dbg_s2 <= 1'b1;
    end else begin
      dbg_s1 <= debug_n_pin;
      dbg_s2 <= dbg_s1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      jtag_grant     <= 1'b0;
      jtag_otp_grant <= 1'b0;
      link_grant     <= 1'b0;
      debug_req      <= 1'b0;
      otp_redundant  <= 1'b0;
      usercode_ext   <= 10'h000;
    end else begin
      jtag_grant     <= sec_valid & jtag_req & ~sec[BIL_SB_NO_JTAG];
      jtag_otp_grant <= sec_valid & jtag_otp_req
                        & ~sec[BIL_SB_NO_JTAG]
                        & ~sec[BIL_SB_NO_JOTP];
      link_grant     <= sec_valid & link_req & ~sec[BIL_SB_NO_LINK];
      debug_req      <= sec_valid & ~dbg_s2 & ~sec[BIL_SB_NO_DEBUG];
      otp_redundant  <= sec_valid & sec[BIL_SB_REDUNDANT];
      usercode_ext   <= sec[BIL_SB_ID_HI:BIL_SB_ID_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // otp programming ports and user field
  assign prog_refused = ~sec_valid | sector_locked(sec, otpa[10:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      otpa         <= 16'h0000;
      otpd         <= 32'h00000000;
      user_field   <= 7'h00;
      otp_prog     <= 1'b0;
      otp_paddr    <= 11'h000;
      otp_pdata    <= 32'h00000000;
    end else begin
      otp_prog <= 1'b0;
      if (reg_req.req && reg_req.write) begin
        unique case (reg_req.addr)
          BIL_REG_OTPA: otpa <= reg_req.wdata[15:0];
          BIL_REG_OTPD: otpd <= reg_req.wdata;
          BIL_REG_OTPC: begin
            // 2048 rows = 4 x 512; top row is the security word
            if ((reg_req.wdata[15:0] & BIL_OTPC_PROG) != 16'h0
                && !prog_refused) begin
              otp_prog  <= 1'b1;
              otp_paddr <= otpa[10:0];
              otp_pdata <= otpd;
            end
          end
          BIL_REG_USER:
            user_field <= reg_req.wdata[BIL_SB_USER_HI:BIL_SB_USER_LO];
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_req.req && !reg_req.write) begin
      unique case (reg_req.addr)
        BIL_REG_SEC:    reg_rdata <= sec;
        BIL_REG_STATUS: reg_rdata <= {26'h0, sec_valid, cpu_start,
                                      boot_fail, state == ST_RUN,
                                      state == ST_FAIL, img_ready};
        BIL_REG_CRC:    reg_rdata <= ~crc;
        BIL_REG_LEN:    reg_rdata <= len_word;
        BIL_REG_OTPA:   reg_rdata <= {16'h0, otpa};
        BIL_REG_OTPD:   reg_rdata <= otpd;
        BIL_REG_OTPC:   reg_rdata <= {31'h0, prog_refused};
        BIL_REG_USER:   reg_rdata <= {10'h0, user_field, 15'h0};
        default:        reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule : bil_loader

// file: bil_chk.sv
// assertions on the boot loader top ports
// bound into every bil_loader; one clock, async active-high reset
module bil_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        img_ready,
  input wire logic        otp_prog,
  input wire logic        cpu_start,
  input wire logic [14:0] cpu_start_addr,
  input wire logic        boot_fail,
  input wire logic        sec_valid,
  input wire logic        jtag_req,
  input wire logic        jtag_grant,
  input wire logic        link_req,
  input wire logic        link_grant,
  input wire logic        debug_n_pin,
  input wire logic        debug_req,
  input wire logic [9:0]  usercode_ext
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  AST_START_AT_ZERO: assert property (
    cpu_start |-> cpu_start_addr == 15'h0000) else $error("start addr");
  AST_START_PULSE: assert property (
    cpu_start |=> !cpu_start) else $error("start not a pulse");
  AST_FAIL_NO_START: assert property (
    boot_fail |-> !cpu_start) else $error("start after fail");
  AST_JTAG_GRANT: assert property (
    jtag_grant |-> $past(jtag_req) && sec_valid) else $error("jtag grant");
  AST_LINK_GRANT: assert property (
    link_grant |-> $past(link_req) && sec_valid) else $error("link grant");
  AST_DEBUG_SYNC: assert property (
    debug_req |-> !$past(debug_n_pin, 3)) else $error("debug request");
  AST_SEC_FROZEN: assert property (
    sec_valid && $past(sec_valid, 2) |-> $stable(usercode_ext))
    else $error("security copy changed");
  AST_LOAD_FIRST: assert property (
    img_ready |-> sec_valid) else $error("image before load");
  AST_PROG_PULSE: assert property (
    otp_prog |-> sec_valid ##1 !otp_prog) else $error("program strobe");
endmodule : bil_chk

bind bil_loader bil_chk bil_chk_inst (.clk, .rst, .img_ready, .otp_prog,
  .cpu_start, .cpu_start_addr, .boot_fail, .sec_valid, .jtag_req,
  .jtag_grant, .link_req, .link_grant, .debug_n_pin, .debug_req,
  .usercode_ext);

// file: bil_src.sv
// boot image source feeding the loader byte port
// tasks are entered just after a rising edge; gap sets idle cycles
module bil_src (
  input  wire logic          clk,
  input  wire logic          img_ready,
  output bil_pkg::bil_byte_s img_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  import bil_pkg::*;
  int gap = 0;
  initial img_byte = '0;
  ////////////////////////////////////////////////////////////////////
  task send_byte(input logic [7:0] b);
    int n;
    n = 0;
    img_byte <= {1'b1, b};
    do begin
      @(posedge clk);
      n++;
    end while (img_ready !== 1'b1 && n < 200);
    if (gap > 0) begin
      img_byte <= {1'b0, ~b};
      repeat (gap) @(posedge clk);
    end
  endtask : send_byte
  task send_word(input logic [31:0] w);
    for (int i = 0; i < 4; i++) send_byte(w[8*i +: 8]);
  endtask : send_word
  task release_line();
    img_byte <= {1'b0, ~img_byte.data};
  endtask : release_line
endmodule : bil_src

// file: tb_top.sv
// self-checking bench for the boot image loader
// otp is a row-number pattern with the security word at its top row
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bil_pkg::*;
  logic clk, rst, img_ready, otp_prog, otp_redundant, ram_we;
  logic cpu_start, boot_fail, sec_valid, debug_n_pin, debug_req;
  logic jtag_req, jtag_grant, jtag_otp_req, jtag_otp_grant;
  logic link_req, link_grant;
  logic [10:0] otp_raddr, otp_paddr, p_addr;
  logic [14:0] ram_addr, cpu_start_addr;
  logic [31:0] otp_rdata, otp_pdata, ram_wdata, reg_rdata, sec_word;
  logic [31:0] p_data;
  logic [9:0]  usercode_ext;
  bil_byte_s    img_byte;
  bil_reg_req_s reg_req;
  logic [31:0] ram_q [0:32767];
  int errors, checks_done, n_start, n_prog;
  assign otp_rdata = (otp_raddr == BIL_OTP_SEC_ADDR) ? sec_word
                                                     : {21'h0, otp_raddr};
  bil_src bil_src_inst (.clk, .img_ready, .img_byte);
  bil_loader bil_loader_inst (.clk, .rst, .img_byte, .img_ready,
    .otp_rdata, .otp_raddr, .otp_prog, .otp_paddr, .otp_pdata,
    .otp_redundant, .ram_we, .ram_addr, .ram_wdata, .cpu_start,
    .cpu_start_addr, .boot_fail, .sec_valid, .jtag_req, .jtag_grant,
    .jtag_otp_req, .jtag_otp_grant, .link_req, .link_grant, .debug_n_pin,
    .debug_req, .usercode_ext, .reg_req, .reg_rdata);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ram_we) ram_q[ram_addr] = ram_wdata;
    if (cpu_start) n_start++;
    if (otp_prog) begin
      n_prog++;
      p_addr = otp_paddr;
      p_data = otp_pdata;
    end
  end
  ////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task do_reset(input logic [31:0] s);
    rst <= 1'b1;
    sec_word <= s;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    n_start = 0;
    n_prog = 0;
    repeat (3) @(posedge clk);
    #1;
  endtask : do_reset
  task reg_wr(input logic [3:0] a, input logic [31:0] d);
    reg_req <= {1'b1, 1'b1, a, d};
    @(posedge clk);
    reg_req <= '0;
    @(posedge clk);
  endtask : reg_wr
  task rd_chk(input logic [3:0] a, input logic [31:0] e,
              input logic [31:0] m = 32'hFFFFFFFF);
    reg_req <= {1'b1, 1'b0, a, 32'h0};
    @(posedge clk);
    reg_req <= '0;
    #1 chk(reg_rdata & m, e);
    @(posedge clk);
  endtask : rd_chk
  function automatic logic [31:0] crc8(input logic [31:0] c,
                                       input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ BIL_CRC_POLY : c >> 1;
    return c;
  endfunction : crc8
  function automatic logic [31:0] pword(input int i);
    return 32'hC35A0000 + i * 32'h00010203;
  endfunction : pword
  ////////////////////////////////////////////////////////////////////
  task t_access(input logic [31:0] s);
    do_reset(s);
    rd_chk(BIL_REG_SEC, s);
    rd_chk(4'hF, 32'h0);
    jtag_req <= 1'b1;
    link_req <= 1'b1;
    jtag_otp_req <= 1'b1;
    debug_n_pin <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(jtag_grant, !s[0]);
    chk(link_grant, !s[1]);
    chk(jtag_otp_grant, !s[0] && !s[13]);
    chk(debug_req, !s[14]);
    chk(otp_redundant, s[7]);
    chk(usercode_ext, s[31:22]);
    jtag_req <= 1'b0;
    link_req <= 1'b0;
    jtag_otp_req <= 1'b0;
    debug_n_pin <= 1'b1;
    @(posedge clk);
    $display("access test done");
  endtask : t_access
  task t_boot(input int len, input int mode, input int gap);
    logic [31:0] c, w;
    do_reset(32'h0);
    bil_src_inst.gap = gap;
    c = BIL_CRC_PRESET;
    for (int i = -1; i < len; i++) begin
      w = (i < 0) ? len : pword(i);
      for (int k = 0; k < 4; k++) c = crc8(c, w[8*k +: 8]);
      bil_src_inst.send_word(w);
    end
    c = ~c;
    bil_src_inst.send_word(mode == 1 ? BIL_BYPASS_WORD :
                           (mode == 2 ? ~c : c));
    bil_src_inst.release_line();
    repeat (4) @(posedge clk);
    #1 chk(n_start, mode != 2);
    chk(boot_fail, mode == 2);
    for (int i = 0; i < len; i++) chk(ram_q[i], pword(i));
    if (mode != 1) rd_chk(BIL_REG_CRC, c);
    $display("boot test done");
  endtask : t_boot
  task t_prog(input logic [10:0] row, input logic [31:0] s, input bit ok);
    do_reset(s);
    reg_wr(BIL_REG_OTPA, {21'h0, row});
    reg_wr(BIL_REG_OTPD, {21'h0, row} ^ 32'h5A5A0000);
    reg_wr(BIL_REG_OTPC, {16'h0, BIL_OTPC_PROG});
    repeat (3) @(posedge clk);
    chk(n_prog, ok);
    rd_chk(BIL_REG_OTPC, !ok, 32'h1);
    if (ok) chk(p_addr, row);
    if (ok) chk(p_data, {21'h0, row} ^ 32'h5A5A0000);
    $display("program test done");
  endtask : t_prog
  task t_secure();
    int n;
    do_reset(32'h00000020);
    chk(img_ready, 1'b0);
    n = 0;
    while (n_start == 0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    #1 chk(n_start, 1);
    chk(ram_q[3], 32'h3);
    chk(ram_q[15'h07FE], 32'h7FE);
    $display("secure boot test done");
  endtask : t_secure
  ////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    sec_word = 32'h0;
    reg_req = '0;
    {jtag_req, link_req, jtag_otp_req} = 3'h0;
    debug_n_pin = 1'b1;
    {errors, checks_done} = 0;
    t_access(32'h00000000);
    t_access(32'hAD406083);
    t_access(32'h00002000);
    t_boot(3, 0, 0);
    t_boot(0, 1, 2);
    t_boot(2, 2, 1);
    t_prog(11'h200, 32'h00000200, 1'b0);
    t_prog(11'h005, 32'h00000200, 1'b1);
    t_prog(11'h7FE, 32'h00000800, 1'b0);
    t_prog(11'h005, 32'h00001000, 1'b0);
    t_secure();
    wrap_up();
  end
  initial begin
    #(100 * 20000);
    errors++;
    $display("unexpected at %0t: watchdog", $time);
    wrap_up();
  end
endmodule : tb_top
